// file: core/aas_consts.svh
// Constants for the active antenna supervisor
`ifndef AAS_CONSTS_SVH
`define AAS_CONSTS_SVH

`define AAS_ADDR_W        8
`define AAS_DATA_W        32
`define AAS_REG_CTRL      8'h00
`define AAS_REG_STATUS    8'h04
`define AAS_REG_SUMMARY   8'h08
`define AAS_REG_INT_STAT  8'h0C
`define AAS_REG_INT_MASK  8'h10
`define AAS_CTRL_RST      4'h0
`define AAS_MASK_RST      4'h0

`define AAS_EVT_CHANGE    0
`define AAS_EVT_FAULT     1
`define AAS_EVT_OPEN      2
`define AAS_EVT_ANNOUNCE  3

`define AAS_CLK_KHZ       25000
`define AAS_RETRY_TIME_MS 1000
`define AAS_RETRY_CYC     (`AAS_RETRY_TIME_MS * `AAS_CLK_KHZ)
`define AAS_SETTLE_CYC    2'h3

`endif

// file: core/aas_pkg.sv
// Types for the active antenna supervisor
package aas_pkg;

    typedef enum logic [1:0] {
        AAS_COND_INIT,
        AAS_COND_OK,
        AAS_COND_SHORT,
        AAS_COND_OPEN
    } aas_cond_e;

    typedef struct packed {
        logic presence_detect_enable;
        logic fault_auto_retry_enable;
        logic fault_detect_enable;
        logic supply_control_enable;
    } aas_ctrl_s;

    typedef struct packed {
        logic announce;
        logic open_hit;
        logic fault_hit;
        logic cond_change;
    } aas_evt_s;

    typedef struct packed {
        logic sr;
        logic pdos;
        logic od;
        logic sd;
        logic ac;
    } aas_summary_s;

endpackage

// file: core/aas_sync.sv
// Two-stage synchroniser for the antenna sense pins
`timescale 1ns/100ps
module aas_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // Pins idle high through their pull-ups
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1   <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// file: core/aas_retry_timer.sv
// Retry timeout counter for short recovery
`timescale 1ns/100ps
module aas_retry_timer #(
    parameter int            CW      = 32,
    parameter logic [CW-1:0] LOAD_M1 = 32'h0000_0003
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic start,
    input  wire logic cancel,
    output logic      done
);
    logic [CW-1:0] cnt;
    logic          busy;

    assign done = busy && (cnt == '0);

    // Start wins over cancel
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt  <= '0;
            busy <= 1'b0;
        end else if (start) begin
            cnt  <= LOAD_M1;
            busy <= 1'b1;
        end else if (cancel || done) begin
            busy <= 1'b0;
        end else if (busy) begin
            cnt  <= cnt - CW'(1);
        end
    end
endmodule

// file: core/aas_supervisor.sv
// Active antenna supervisor with register port and interrupt
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "aas_consts.svh"
module aas_supervisor
    import aas_pkg::*;
#(
    parameter int RETRY_CYCLES = `AAS_RETRY_CYC,
    parameter int TIMER_W      = 32
) (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic [`AAS_ADDR_W-1:0] reg_addr,
    input  wire logic [`AAS_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`AAS_DATA_W-1:0] reg_rdata,
    input  wire logic                   antenna_fault_sense_low,
    input  wire logic                   antenna_presence_input,
    output logic                        antenna_power_off,
    output aas_cond_e                   antenna_condition,
    output logic                        antenna_irq
);

    logic [1:0]   pins_s;
    aas_ctrl_s    ctrl;
    aas_cond_e    cond;
    aas_cond_e    next_cond;
    logic         retesting;
    logic         next_retest;
    logic [1:0]   settle;
    logic [1:0]   next_settle;
    logic         next_power_off;
    logic         timer_start;
    logic         timer_done;
    logic         supply_q;
    logic [3:0]   int_stat;
    logic [3:0]   int_mask;
    aas_evt_s     evt;
    aas_summary_s summary;
    logic [31:0]  rd_word;

    // Sense pins through the synchroniser
    aas_sync #(
        .WIDTH (2)
    ) u_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in ({antenna_fault_sense_low, antenna_presence_input}),
        .sync_out (pins_s)
    );

    wire logic fault_seen    = ~pins_s[1];
    wire logic presence_seen = pins_s[0];

    wire logic sup_on   = ctrl.supply_control_enable;
    wire logic fault_en = ctrl.fault_detect_enable;
    wire logic retry_en = ctrl.fault_auto_retry_enable;
    wire logic open_en  = ctrl.presence_detect_enable;

    // Exact address match for one register
    function automatic logic addr_hit(input logic [`AAS_ADDR_W-1:0] a,
                                      input logic [`AAS_ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Register decode
    wire logic wr_ctrl = reg_wr && addr_hit(reg_addr, `AAS_REG_CTRL);
    wire logic wr_stat = reg_wr && addr_hit(reg_addr, `AAS_REG_INT_STAT);
    wire logic wr_mask = reg_wr && addr_hit(reg_addr, `AAS_REG_INT_MASK);

    // Retry timeout
    wire logic timer_cancel = !(cond == AAS_COND_SHORT && retry_en);

    aas_retry_timer #(
        .CW      (TIMER_W),
        .LOAD_M1 (TIMER_W'(RETRY_CYCLES - 1))
    ) u_timer (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .start   (timer_start),
        .cancel  (timer_cancel),
        .done    (timer_done)
    );

    // Condition tracking
    always_comb begin
        next_cond   = cond;
        next_retest = retesting;
        next_settle = settle;
        if (!sup_on) begin
            next_cond   = AAS_COND_INIT;
            next_retest = 1'b0;
            next_settle = 2'h0;
        end else begin
            unique case (cond)
                AAS_COND_INIT: begin
                    next_cond = AAS_COND_OK;
                end
                AAS_COND_OK, AAS_COND_OPEN: begin
                    if (fault_en && fault_seen) begin
                        next_cond   = AAS_COND_SHORT;
                    end else if (open_en && !presence_seen) begin
                        next_cond = AAS_COND_OPEN;
                    end else begin
                        next_cond = AAS_COND_OK;
                    end
                end
                AAS_COND_SHORT: begin
                    if (!fault_en) begin
                        next_cond   = AAS_COND_OK;
                        next_retest = 1'b0;
                    end else if (retesting) begin
                        if (settle != 2'h0) begin
                            next_settle = 2'(settle - 2'h1);
                        end else if (fault_seen) begin
                            next_retest = 1'b0;
                        end else begin
                            next_cond   = AAS_COND_OK;
                            next_retest = 1'b0;
                        end
                    end else if (timer_done) begin
                        next_retest = 1'b1;
                        next_settle = `AAS_SETTLE_CYC;
                    end
                end
            endcase
        end
    end

    // Power removed only for a latched short with auto retry
    assign next_power_off = sup_on && retry_en && (next_cond == AAS_COND_SHORT)
                            && !next_retest;

    // Timer restarts each time power is cut
    assign timer_start = next_power_off && !antenna_power_off;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond              <= AAS_COND_INIT;
            retesting         <= 1'b0;
            settle            <= 2'h0;
            antenna_power_off <= 1'b0;
            supply_q          <= 1'b0;
        end else begin
            cond              <= next_cond;
            retesting         <= next_retest;
            settle            <= next_settle;
            antenna_power_off <= next_power_off;
            supply_q          <= sup_on;
        end
    end

    assign antenna_condition = cond;

    // Active function summary
    assign summary.ac   = sup_on;
    assign summary.sd   = sup_on && fault_en;
    assign summary.od   = sup_on && open_en;
    assign summary.pdos = sup_on && fault_en && retry_en;
    assign summary.sr   = sup_on && fault_en && retry_en;

    // Events
    assign evt.cond_change = (next_cond != cond);
    assign evt.fault_hit   = (next_cond == AAS_COND_SHORT) && (cond != AAS_COND_SHORT);
    assign evt.open_hit    = (next_cond == AAS_COND_OPEN) && (cond != AAS_COND_OPEN);
    assign evt.announce    = sup_on && !supply_q;

    // Registers; set wins over write-one-to-clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl     <= aas_ctrl_s'(`AAS_CTRL_RST);
            int_mask <= `AAS_MASK_RST;
            int_stat <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= aas_ctrl_s'(reg_wdata[3:0]);
            end
            if (wr_mask) begin
                int_mask <= reg_wdata[3:0];
            end
            int_stat <= (int_stat & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | evt;
        end
    end

    assign antenna_irq = |(int_stat & int_mask);

    // Read selection
    assign rd_word = addr_hit(reg_addr, `AAS_REG_CTRL)     ? {28'h0, ctrl} :
                     addr_hit(reg_addr, `AAS_REG_STATUS)   ? {28'h0, retesting,
                                                            !antenna_power_off, cond} :
                     addr_hit(reg_addr, `AAS_REG_SUMMARY)  ? {27'h0, summary} :
                     addr_hit(reg_addr, `AAS_REG_INT_STAT) ? {28'h0, int_stat} :
                     addr_hit(reg_addr, `AAS_REG_INT_MASK) ? {28'h0, int_mask} :
                     32'h0000_0000;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
        end
    end

    // Checks
    logic [TIMER_W-1:0] off_cnt;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            off_cnt <= '0;
        end else if (antenna_power_off) begin
            off_cnt <= off_cnt + TIMER_W'(1);
        end else begin
            off_cnt <= '0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    no_report_off_a: assert property (
        !sup_on |=> cond == AAS_COND_INIT && !antenna_power_off
    ) else $error("Condition reported with supply control off");

    ctrl_write_a: assert property (
        wr_ctrl |=> ctrl == aas_ctrl_s'($past(reg_wdata[3:0]))
    ) else $error("Enable write not taken");

    off_means_short_a: assert property (
        antenna_power_off |-> cond == AAS_COND_SHORT && !retesting
    ) else $error("Power off outside a latched short");

    fault_sense_a: assert property (
        sup_on && fault_en && cond == AAS_COND_OK && fault_seen
        |=> cond == AAS_COND_SHORT
    ) else $error("Low fault sense not taken as short");

    no_power_down_a: assert property (
        !retry_en |=> !antenna_power_off
    ) else $error("Power removed without auto retry");

    short_latch_a: assert property (
        cond == AAS_COND_SHORT && sup_on && fault_en && !retesting && !timer_done
        |=> cond == AAS_COND_SHORT
    ) else $error("Short condition lost while latched");

    short_off_a: assert property (
        sup_on && fault_en && retry_en && cond == AAS_COND_OK && fault_seen
        |=> cond == AAS_COND_SHORT && antenna_power_off
    ) else $error("Short with retry did not remove power");

    retest_low_a: assert property (
        cond == AAS_COND_SHORT && sup_on && fault_en && retry_en && !retesting
        && timer_done |=> !antenna_power_off && retesting
    ) else $error("Retest did not restore power");

    retest_ok_a: assert property (
        cond == AAS_COND_SHORT && sup_on && fault_en && retesting
        && settle == 2'h0 && !fault_seen |=> cond == AAS_COND_OK
    ) else $error("Clean retest did not report OK");

    open_report_a: assert property (
        sup_on && open_en && cond == AAS_COND_OK && !(fault_en && fault_seen)
        && !presence_seen |=> cond == AAS_COND_OPEN ##0 int_stat[`AAS_EVT_OPEN]
    ) else $error("Missing presence not reported as open");

    open_clear_a: assert property (
        sup_on && cond == AAS_COND_OPEN && presence_seen && !(fault_en && fault_seen)
        |=> cond == AAS_COND_OK
    ) else $error("Presence back but open kept");

    init_then_ok_a: assert property (
        $rose(sup_on) |-> cond == AAS_COND_INIT ##1 (cond == AAS_COND_OK || !sup_on)
    ) else $error("Start-up did not pass INIT then OK");

    announce_a: assert property (
        $rose(sup_on) |=> int_stat[`AAS_EVT_ANNOUNCE] && summary.ac
    ) else $error("Start-up summary not announced");

    retry_time_a: assert property (
        timer_done && antenna_power_off |-> off_cnt == TIMER_W'(RETRY_CYCLES - 1)
    ) else $error("Retest not at the retry timeout");

    short_prio_a: assert property (
        sup_on && fault_en && cond == AAS_COND_OPEN && fault_seen
        |=> cond == AAS_COND_SHORT
    ) else $error("Short not taken over open");

    short_event_a: assert property (
        sup_on && fault_en && cond == AAS_COND_OK && fault_seen
        |=> int_stat[`AAS_EVT_FAULT]
    ) else $error("Short entry not flagged");

    fault_off_clear_a: assert property (
        sup_on && !fault_en && cond == AAS_COND_SHORT
        |=> cond == AAS_COND_OK
    ) else $error("Short kept with fault detect off");

    short_needs_en_a: assert property (
        !fault_en
        |=> cond != AAS_COND_SHORT
    ) else $error("Short reported with fault detect off");

    retest_fail_a: assert property (
        cond == AAS_COND_SHORT && sup_on && fault_en && retry_en && retesting
        && settle == 2'h0 && fault_seen |=> antenna_power_off && !retesting
    ) else $error("Failed retest did not remove power");

    retest_settle_a: assert property (
        cond == AAS_COND_SHORT && sup_on && fault_en && retesting && settle != 2'h0
        |=> retesting && !antenna_power_off
    ) else $error("Retest cut short");

    retry_hold_a: assert property (
        antenna_power_off && sup_on && fault_en && retry_en && !timer_done
        |=> antenna_power_off
    ) else $error("Power restored before the retry timeout");

    open_ignored_a: assert property (
        sup_on && !open_en && cond == AAS_COND_OK && !(fault_en && fault_seen)
        |=> cond == AAS_COND_OK
    ) else $error("Open reported with presence detect off");

    retry_cycle_c: cover property (
        cond == AAS_COND_SHORT && antenna_power_off ##1 retesting [*4]
        ##1 cond == AAS_COND_OK
    );

    short_kept_c: cover property (
        cond == AAS_COND_SHORT && !retry_en && !antenna_power_off [*8]
    );

    open_ok_c: cover property (
        cond == AAS_COND_OPEN ##[1:50] cond == AAS_COND_OK
    );

    irq_c: cover property (
        $rose(antenna_irq)
    );

    retest_fail_c: cover property (
        cond == AAS_COND_SHORT && retesting ##1 antenna_power_off
    );

endmodule

// file: tb/aas_antenna_model.sv
// Behavioural model of the antenna bias and current-sense circuit
`timescale 1ns/100ps
module aas_antenna_model (
    input  wire logic antenna_power_off,
    input  wire logic short_req,
    input  wire logic absent_req,
    output logic      antenna_fault_sense_low,
    output logic      antenna_presence_input
);
    wire logic powered;

    assign powered = ~antenna_power_off;
    // Short pulls low only while biased, pull-up otherwise
    assign antenna_fault_sense_low = ~(short_req & powered);
    // No current without antenna or bias pulls low, pull-up otherwise
    assign antenna_presence_input = ~absent_req & powered;
endmodule

// file: tb/active_antenna_supervisor_tb.sv
// Self-checking testbench for the active antenna supervisor
`timescale 1ns/100ps
`include "aas_consts.svh"
module active_antenna_supervisor_tb
    import aas_pkg::*;
;
    localparam int RT = 20;
    logic        sys_clk;
    logic        arst_n;
    logic        reg_wr;
    logic        reg_rd;
    logic        short_req;
    logic        absent_req;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic        antenna_power_off;
    logic        antenna_fault_sense_low;
    logic        antenna_presence_input;
    logic        antenna_irq;
    aas_cond_e   antenna_condition;
    logic [3:0]  cfg [5] = '{4'h1, 4'h3, 4'h7, 4'hB, 4'hF};
    int          fails = 0;
    int          tests_run = 0;
    int          hi;

    initial sys_clk = 1'h0;
    always #20 sys_clk = ~sys_clk;

    aas_supervisor #(.RETRY_CYCLES(RT), .TIMER_W(32)) u_aas_supervisor (
        .sys_clk                 (sys_clk),
        .arst_n                  (arst_n),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_wr                  (reg_wr),
        .reg_rd                  (reg_rd),
        .reg_rdata               (reg_rdata),
        .antenna_fault_sense_low (antenna_fault_sense_low),
        .antenna_presence_input  (antenna_presence_input),
        .antenna_power_off       (antenna_power_off),
        .antenna_condition       (antenna_condition),
        .antenna_irq             (antenna_irq)
    );

    aas_antenna_model u_aas_antenna_model (
        .antenna_power_off       (antenna_power_off),
        .short_req               (short_req),
        .absent_req              (absent_req),
        .antenna_fault_sense_low (antenna_fault_sense_low),
        .antenna_presence_input  (antenna_presence_input)
    );

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 rv = reg_rdata;
        check(rv, e);
    endtask

    task automatic pins(input logic s, input logic a);
        @(posedge sys_clk);
        short_req  <= s;
        absent_req <= a;
        #1;
    endtask

    task automatic wait_cond(input aas_cond_e e, input int lim);
        int n = 0;
        while (antenna_condition !== e && n < lim) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(antenna_condition, e);
    endtask

    function automatic logic [31:0] summ(input logic [3:0] c);
        logic r;
        r = c[0] & c[1] & c[2];
        return {27'h0, r, r, c[0] & c[3], c[0] & c[1], c[0]};
    endfunction

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        complete_run();
    end

    initial begin
        {reg_wr, reg_rd, short_req, absent_req, arst_n} = 5'h0;
        reg_addr  = 8'h0;
        reg_wdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        check(antenna_power_off, 32'h0);
        check(antenna_condition, AAS_COND_INIT);
        arst_n <= 1'h1;
        rchk(`AAS_REG_CTRL, 32'h0);
        rchk(`AAS_REG_INT_MASK, 32'h0);
        rchk(8'h14, 32'h0);
        // Supervision off: faults ignored
        wr(`AAS_REG_CTRL, 32'hE);
        pins(1'h1, 1'h1);
        repeat (8) @(posedge sys_clk);
        #1 check(antenna_condition, AAS_COND_INIT);
        check(antenna_power_off, 32'h0);
        rchk(`AAS_REG_SUMMARY, 32'h0);
        pins(1'h0, 1'h0);
        wr(`AAS_REG_CTRL, 32'h0);
        // Start-up: INIT then OK, announce interrupt
        wr(`AAS_REG_INT_MASK, 32'hF);
        wr(`AAS_REG_CTRL, 32'h1);
        check(antenna_condition, AAS_COND_INIT);
        @(posedge sys_clk);
        #1 check(antenna_condition, AAS_COND_OK);
        check(antenna_irq, 32'h1);
        rchk(`AAS_REG_INT_STAT, 32'h9);
        wr(`AAS_REG_INT_MASK, 32'h7);
        check(antenna_irq, 32'h1);
        wr(`AAS_REG_INT_STAT, 32'h1);
        check(antenna_irq, 32'h0);
        wr(`AAS_REG_INT_STAT, 32'h8);
        rchk(`AAS_REG_INT_STAT, 32'h0);
        foreach (cfg[i]) begin
            wr(`AAS_REG_CTRL, {28'h0, cfg[i]});
            rchk(`AAS_REG_SUMMARY, summ(cfg[i]));
        end
        // Short without power-down stays latched
        wr(`AAS_REG_CTRL, 32'h3);
        pins(1'h1, 1'h0);
        wait_cond(AAS_COND_SHORT, 10);
        check(antenna_power_off, 32'h0);
        rchk(`AAS_REG_STATUS, 32'h6);
        pins(1'h0, 1'h0);
        repeat (2 * RT) @(posedge sys_clk);
        #1 check(antenna_condition, AAS_COND_SHORT);
        wr(`AAS_REG_CTRL, 32'h1);
        wr(`AAS_REG_CTRL, 32'h3);
        wait_cond(AAS_COND_OK, 4);
        // Short with auto retry, still shorted at first retest
        wr(`AAS_REG_CTRL, 32'h7);
        pins(1'h1, 1'h0);
        wait_cond(AAS_COND_SHORT, 10);
        check(antenna_power_off, 32'h1);
        hi = 0;
        while (antenna_power_off === 1'h1 && hi < 100) begin
            @(posedge sys_clk);
            #1 hi++;
        end
        check(hi >= RT, 32'h1);
        check(hi <= RT + 2, 32'h1);
        wait_cond(AAS_COND_SHORT, 1);
        repeat (6) @(posedge sys_clk);
        #1 check(antenna_power_off, 32'h1);
        rchk(`AAS_REG_STATUS, 32'h2);
        pins(1'h0, 1'h0);
        wait_cond(AAS_COND_OK, 2 * RT + 20);
        check(antenna_power_off, 32'h0);
        rchk(`AAS_REG_STATUS, 32'h5);
        // Presence ignored with open detection off
        pins(1'h0, 1'h1);
        repeat (6) @(posedge sys_clk);
        #1 check(antenna_condition, AAS_COND_OK);
        pins(1'h0, 1'h0);
        // Open detection and recovery
        wr(`AAS_REG_CTRL, 32'hF);
        wr(`AAS_REG_INT_STAT, 32'hF);
        pins(1'h0, 1'h1);
        wait_cond(AAS_COND_OPEN, 10);
        rchk(`AAS_REG_INT_STAT, 32'h5);
        pins(1'h0, 1'h0);
        wait_cond(AAS_COND_OK, 10);
        // Short wins over open; reset clears the latch
        wr(`AAS_REG_CTRL, 32'hB);
        pins(1'h0, 1'h1);
        wait_cond(AAS_COND_OPEN, 10);
        pins(1'h1, 1'h1);
        wait_cond(AAS_COND_SHORT, 10);
        check(antenna_power_off, 32'h0);
        pins(1'h0, 1'h0);
        @(posedge sys_clk);
        arst_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'h1;
        #1 check(antenna_condition, AAS_COND_INIT);
        check(antenna_power_off, 32'h0);
        rchk(`AAS_REG_CTRL, 32'h0);
        wr(`AAS_REG_CTRL, 32'h3);
        wait_cond(AAS_COND_OK, 4);
        complete_run();
    end
endmodule
